// ### common/burst_pkg.sv
// Shared constants and types for the initiator burst controller
package burst_pkg;

   // ----------------------------------------------------------------
   // Address pointer layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int PTR_LSB = 2;
   localparam int PTR_W = ADDR_W - PTR_LSB;
   localparam logic [PTR_W-1:0] PTR_RESET = 30'h0000_0000;
   localparam logic [PTR_LSB-1:0] PTR_LOW_BITS = 2'h0;

   // ----------------------------------------------------------------
   // Data path and FIFO sizing
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int BACKUP_MAX = 2;
   localparam int ALMOST_EMPTY_LEVEL = 2;
   localparam int ALMOST_FULL_MARGIN = 2;
   localparam int OVER_W = 4;
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Transfer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {IDLE_ST, READ_ST, WRITE_ST} xfer_state_type;

endpackage

// ### common/fifo_if.sv
// Connection between the burst controller and its back-up FIFO
`timescale 1ns/10ps
interface fifo_if #(
   parameter int W = 32,
   parameter int CW = 5
);
   logic push;
   logic [W-1:0] push_data;
   logic pop;
   logic backup;
   logic [1:0] backup_count;
   logic [W-1:0] head;
   logic [W-1:0] head_next;
   logic [CW-1:0] count;
   logic empty_flag;
   logic full_flag;
   logic low_flag;
   logic high_flag;

   modport ctrl (output push, push_data, pop, backup, backup_count,
      input head, head_next, count, empty_flag, full_flag, low_flag,
      high_flag);
   modport store (input push, push_data, pop, backup, backup_count,
      output head, head_next, count, empty_flag, full_flag, low_flag,
      high_flag);
endinterface

// ### design/backup_fifo.sv
// Circular FIFO with a bidirectional read pointer for undoing reads
`timescale 1ns/10ps
module backup_fifo #(
   parameter int DEPTH = burst_pkg::FIFO_DEPTH,
   parameter int W = burst_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic rst_n,
   fifo_if.store f
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] USABLE = CW'(DEPTH - burst_pkg::BACKUP_MAX);
   localparam logic [CW-1:0] LOW_LEVEL = CW'(burst_pkg::ALMOST_EMPTY_LEVEL);
   localparam logic [CW-1:0] HIGH_LEVEL =
      CW'(DEPTH - burst_pkg::BACKUP_MAX - burst_pkg::ALMOST_FULL_MARGIN);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] rd_reg, rd_next, wr_reg, wr_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic empty_reg, empty_next, full_reg, full_next;
   logic low_reg, low_next, high_reg, high_next;

   // ----------------------------------------------------------------
   // Pointer and occupancy update
   // ----------------------------------------------------------------
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (f.push) begin
         wr_next = wr_reg + AW'(1);
         cnt_next = cnt_next + CW'(1);
      end
      if (f.backup) begin
         rd_next = rd_reg - AW'(f.backup_count);
         cnt_next = cnt_next + CW'(f.backup_count);
      end else if (f.pop) begin
         rd_next = rd_reg + AW'(1);
         cnt_next = cnt_next - CW'(1);
      end
      // Room for two undone words is held back from the writer
      empty_next = (cnt_next == CW'(0));
      full_next = (cnt_next >= USABLE);
      low_next = (cnt_next <= LOW_LEVEL);
      high_next = (cnt_next >= HIGH_LEVEL);
   end

   // Registers of the FIFO control state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= '0;
         wr_reg <= '0;
         cnt_reg <= '0;
         empty_reg <= 1'b1;
         full_reg <= 1'b0;
         low_reg <= 1'b1;
         high_reg <= 1'b0;
      end else begin
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         cnt_reg <= cnt_next;
         empty_reg <= empty_next;
         full_reg <= full_next;
         low_reg <= low_next;
         high_reg <= high_next;
      end
   end

   // Storage array, written without reset
   always_ff @(posedge clk) begin
      if (f.push) begin
         mem[wr_reg] <= f.push_data;
      end
   end

   assign f.head = mem[rd_reg];
   assign f.head_next = mem[rd_reg + AW'(1)];
   assign f.count = cnt_reg;
   assign f.empty_flag = empty_reg;
   assign f.full_flag = full_reg;
   assign f.low_flag = low_reg;
   assign f.high_flag = high_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence undo_s;
      f.backup && !f.push;
   endsequence

   backup_restore_a: assert property (undo_s |=>
      cnt_reg == $past(cnt_reg) + CW'($past(f.backup_count)))
      else $error("Backup did not restore the occupancy");
   depth_cap_a: assert property (cnt_reg <= CW'(DEPTH))
      else $error("FIFO occupancy beyond storage");
endmodule

// ### design/burst_user_logic.sv
// Initiator burst controller: address pointer, data sink and source
`timescale 1ns/10ps
module burst_user_logic #(
   parameter int DEPTH = burst_pkg::FIFO_DEPTH
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic START,
   input wire logic DIR,
   input wire logic LOCAL_INDEX,
   input wire logic [burst_pkg::ADDR_W-1:0] START_ADDR,
   input wire logic TRANSFER_STOP,
   input wire logic TRANSACTION_END,
   input wire logic PHASE_DONE_STROBE,
   input wire logic SOURCE_ADVANCE_STROBE,
   input wire logic [burst_pkg::DATA_W-1:0] INTERNAL_ADDR_DATA_BUS_IN,
   output logic [burst_pkg::DATA_W-1:0] INTERNAL_ADDR_DATA_BUS_OUT,
   output logic INTERNAL_ADDR_DATA_BUS_OE,
   output logic [burst_pkg::ADDR_W-1:0] ADDR_OUT,
   input wire logic FILL_VALID,
   input wire logic [burst_pkg::DATA_W-1:0] FILL_DATA,
   output logic FILL_READY,
   output logic DRAIN_VALID,
   output logic [burst_pkg::DATA_W-1:0] DRAIN_DATA,
   input wire logic DRAIN_READY,
   output logic TOTALLY_EMPTY_FLAG,
   output logic TOTALLY_FULL_FLAG,
   output logic ALMOST_EMPTY_FLAG,
   output logic ALMOST_FULL_FLAG,
   output logic FINISH_REQUEST,
   output logic REQUEST_ERROR,
   output logic OVERRUN_ERROR,
   output logic BUSY
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = burst_pkg::PTR_W;
   localparam int OW = burst_pkg::OVER_W;
   localparam int DW = burst_pkg::DATA_W;
   localparam logic [OW-1:0] OVER_MAX = {OW{1'b1}};
   localparam logic [OW-1:0] OVER_LIMIT = OW'(burst_pkg::BACKUP_MAX);

   fifo_if #(.W(DW), .CW(CW)) fq ();

   backup_fifo #(.DEPTH(DEPTH), .W(DW)) store_i (
      .clk(MCLK),
      .rst_n(RESETN),
      .f(fq)
   );

   burst_pkg::xfer_state_type state_reg, state_next;
   logic [PW-1:0] addr_reg, addr_next;
   logic [OW-1:0] over_reg, over_next;
   logic [DW-1:0] word_reg, word_next;
   logic oe_reg, oe_next;
   logic fill_rdy_reg, fill_rdy_next;
   logic drain_vld_reg, drain_vld_next;
   logic finish_reg, finish_next;
   logic req_err_reg, req_err_next;
   logic ovr_err_reg, ovr_err_next;
   logic busy_reg, busy_next;
   logic reading, writing, refuse, start_ok, inc, back_addr;
   logic src_pop, drain_pop, core_push, fill_push;
   logic [CW-1:0] remaining;

   // ----------------------------------------------------------------
   // Transfer state and request screening
   // ----------------------------------------------------------------
   assign reading = (state_reg == burst_pkg::READ_ST);
   assign writing = (state_reg == burst_pkg::WRITE_ST);
   // Writes need data, reads need room
   assign refuse = DIR ? fq.empty_flag : fq.full_flag;
   assign start_ok = START && !refuse && (state_reg == burst_pkg::IDLE_ST);

   // Next transfer state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         burst_pkg::IDLE_ST: begin
            if (start_ok) begin
               state_next = DIR ? burst_pkg::WRITE_ST : burst_pkg::READ_ST;
            end
         end
         burst_pkg::READ_ST, burst_pkg::WRITE_ST: begin
            if (TRANSFER_STOP) begin
               state_next = burst_pkg::IDLE_ST;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Address pointer
   // ----------------------------------------------------------------
   // Simple scheme counts done phases; local scheme counts advances on writes only, done phases on reads
   assign inc = (reading && PHASE_DONE_STROBE) ||
      (writing && (LOCAL_INDEX ? SOURCE_ADVANCE_STROBE
                               : PHASE_DONE_STROBE));
   assign back_addr = writing && LOCAL_INDEX && TRANSACTION_END;

   // Pointer kept between transactions, only START reloads it
   always_comb begin
      addr_next = addr_reg;
      if (start_ok) begin
         addr_next = START_ADDR[burst_pkg::ADDR_W-1:burst_pkg::PTR_LSB];
      end else if (back_addr) begin
         addr_next = addr_reg - PW'(over_reg);
      end else if (inc) begin
         addr_next = addr_reg + PW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Over-advance counter for write transactions
   // ----------------------------------------------------------------
   // Advances run ahead of phases that may never complete
   always_comb begin
      over_next = over_reg;
      if (start_ok || TRANSACTION_END) begin
         over_next = '0;
      end else if (writing) begin
         if (SOURCE_ADVANCE_STROBE && !PHASE_DONE_STROBE &&
             over_reg != OVER_MAX) begin
            over_next = over_reg + OW'(1);
         end else if (PHASE_DONE_STROBE && !SOURCE_ADVANCE_STROBE &&
                      over_reg != '0) begin
            over_next = over_reg - OW'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // FIFO traffic
   // ----------------------------------------------------------------
   // Up to two untaken words are pushed back; any further ones are lost
   assign fq.backup = writing && TRANSACTION_END && over_reg != '0;
   assign fq.backup_count = (over_reg >= OVER_LIMIT) ? 2'h2
                                                     : over_reg[1:0];
   assign src_pop = writing && SOURCE_ADVANCE_STROBE && !fq.backup &&
      fq.count != '0;
   assign drain_pop = !writing && drain_vld_reg && DRAIN_READY;
   assign fq.pop = src_pop || drain_pop;
   // Read data is taken in the very cycle the done strobe moves the pointer
   assign core_push = reading && PHASE_DONE_STROBE && !fq.full_flag;
   assign fill_push = FILL_VALID && fill_rdy_reg;
   assign fq.push = core_push || fill_push;
   assign fq.push_data = reading ? INTERNAL_ADDR_DATA_BUS_IN
                                 : FILL_DATA;
   assign remaining = fq.count - CW'(fq.pop);

   // ----------------------------------------------------------------
   // Offered word, handshakes and status
   // ----------------------------------------------------------------
   // The word register tracks the FIFO head, so the next word shows at
   // once after a take; a word fetched from a prefetchable source and
   // never sent returns here from the FIFO head after a backup
   always_comb begin
      if (remaining == '0) begin
         word_next = fq.push_data;
      end else if (fq.pop) begin
         word_next = fq.head_next;
      end else begin
         word_next = fq.head;
      end
      oe_next = (state_next == burst_pkg::WRITE_ST);
      fill_rdy_next = (state_next != burst_pkg::READ_ST) &&
         (fq.count + CW'(fq.push) - CW'(fq.pop) <
          CW'(DEPTH - burst_pkg::BACKUP_MAX));
      drain_vld_next = (state_next != burst_pkg::WRITE_ST) &&
         (remaining + CW'(fq.push) != '0);
      finish_next = (writing && fq.low_flag) ||
         (reading && fq.high_flag);
      // A START while busy is ignored without an error
      req_err_next = START && refuse && !busy_reg;
      ovr_err_next = reading && PHASE_DONE_STROBE && fq.full_flag;
      busy_next = (state_next != burst_pkg::IDLE_ST);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= burst_pkg::IDLE_ST;
         addr_reg <= burst_pkg::PTR_RESET;
         over_reg <= '0;
         word_reg <= burst_pkg::WORD_RESET;
         oe_reg <= 1'b0;
         fill_rdy_reg <= 1'b0;
         drain_vld_reg <= 1'b0;
         finish_reg <= 1'b0;
         req_err_reg <= 1'b0;
         ovr_err_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         over_reg <= over_next;
         word_reg <= word_next;
         oe_reg <= oe_next;
         fill_rdy_reg <= fill_rdy_next;
         drain_vld_reg <= drain_vld_next;
         finish_reg <= finish_next;
         req_err_reg <= req_err_next;
         ovr_err_reg <= ovr_err_next;
         busy_reg <= busy_next;
      end
   end

   // Outputs
   assign ADDR_OUT = {addr_reg, burst_pkg::PTR_LOW_BITS};
   assign INTERNAL_ADDR_DATA_BUS_OUT = word_reg;
   assign INTERNAL_ADDR_DATA_BUS_OE = oe_reg;
   assign DRAIN_DATA = word_reg;
   assign DRAIN_VALID = drain_vld_reg;
   assign FILL_READY = fill_rdy_reg;
   assign TOTALLY_EMPTY_FLAG = fq.empty_flag;
   assign TOTALLY_FULL_FLAG = fq.full_flag;
   assign ALMOST_EMPTY_FLAG = fq.low_flag;
   assign ALMOST_FULL_FLAG = fq.high_flag;
   assign FINISH_REQUEST = finish_reg;
   assign REQUEST_ERROR = req_err_reg;
   assign OVERRUN_ERROR = ovr_err_reg;
   assign BUSY = busy_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   sequence load_s;
      start_ok;
   endsequence
   sequence done_step_s;
      !start_ok && !back_addr && inc;
   endsequence
   sequence take_s;
      src_pop && fq.count > CW'(1) && !fq.push;
   endsequence
   sequence capture_s;
      fq.push && fq.push_data == INTERNAL_ADDR_DATA_BUS_IN ##1
      !fq.empty_flag;
   endsequence
   sequence drop_s;
      !fq.push ##1 OVERRUN_ERROR;
   endsequence

   addr_load_a: assert property (load_s |=>
      ADDR_OUT[31:2] == $past(START_ADDR[31:2]))
      else $error("Pointer not loaded from start address");
   low_bits_a: assert property (ADDR_OUT[1:0] == 2'h0)
      else $error("Address low bits not zero");
   addr_step_a: assert property (done_step_s |=>
      addr_reg == $past(addr_reg) + PW'(1))
      else $error("Pointer did not step by one doubleword");
   simple_hold_a: assert property (!start_ok && !LOCAL_INDEX &&
      !PHASE_DONE_STROBE |=> addr_reg == $past(addr_reg))
      else $error("Simple pointer moved without a done phase");
   addr_backup_a: assert property (!start_ok && back_addr |=>
      addr_reg == $past(addr_reg) - PW'($past(over_reg)))
      else $error("Local pointer not backed up");
   read_capture_a: assert property (reading && PHASE_DONE_STROBE &&
      !fq.full_flag |-> capture_s)
      else $error("Read word not captured");
   full_drop_a: assert property (reading && PHASE_DONE_STROBE &&
      fq.full_flag |-> drop_s)
      else $error("Read word pushed into a full FIFO");
   next_word_a: assert property (take_s |=>
      INTERNAL_ADDR_DATA_BUS_OUT == $past(fq.head_next))
      else $error("Next word not offered after a take");
   over_count_a: assert property (writing && !TRANSACTION_END &&
      SOURCE_ADVANCE_STROBE && !PHASE_DONE_STROBE && over_reg < OVER_LIMIT
      |=> over_reg == $past(over_reg) + OW'(1))
      else $error("Over-advance count not raised");
   backup_cap_a: assert property (fq.backup |->
      fq.backup_count inside {2'h1, 2'h2} &&
      OW'(fq.backup_count) <= over_reg)
      else $error("Backup count not limited to two");
   start_refuse_a: assert property (START && refuse && !busy_reg |=>
      REQUEST_ERROR && $stable(state_reg))
      else $error("Refused request started anyway");
   finish_req_a: assert property (writing && fq.low_flag |=>
      FINISH_REQUEST)
      else $error("Finish not requested on almost empty");
endmodule

// ### verif/core_model.sv
// Partner model of the bus-interface core initiator data path
`timescale 1ns/10ps
module core_model (
   input wire logic clk,
   input wire logic [31:0] bus_out,
   output logic done,
   output logic adv,
   output logic tend,
   output logic [31:0] bus_in,
   output logic [31:0] taken_word,
   output logic taken_valid
);
   logic [31:0] last;
   // Quiet core at time zero
   initial begin
      done = 1'b0;
      adv = 1'b0;
      tend = 1'b0;
      bus_in = 32'h0000_0000;
      last = 32'h0000_0000;
   end
   // One core cycle; an advance may be followed by no transfer
   task automatic step(input logic a, input logic d, input logic e,
      input logic [31:0] w);
      @(negedge clk);
      adv = a;
      done = d;
      tend = e;
      if (d) begin
         last = w;
      end
      bus_in = d ? w : ~last; // Released bus never repeats the word
   endtask
   // Core latches the offered word at each advance and holds it
   always @(posedge clk) begin
      taken_valid <= adv;
      if (adv) begin
         taken_word <= bus_out;
      end
   end
endmodule

// ### verif/initiator_burst_pointer_fifo_tb_top.sv
// Self-checking bench for the initiator burst controller
`timescale 1ns/10ps
module initiator_burst_pointer_fifo_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic start_req = 1'b0;
   logic dir = 1'b0;
   logic local_idx = 1'b0;
   logic [31:0] start_addr = 32'h0000_0000;
   logic stop_req = 1'b0;
   logic fill_valid = 1'b0;
   logic [31:0] fill_data = 32'h0000_0000;
   logic drain_ready = 1'b0;
   logic done, adv, tend, taken_valid, oe, fill_ready, drain_valid;
   logic t_empty, t_full, a_empty, a_full, finish_req, req_err;
   logic ovr_err, busy;
   logic [31:0] bus_in, bus_out, taken_word, addr, drain_data, base, w;
   logic [31:0] fw [20];
   logic [31:0] drain_q [$];
   logic [31:0] core_q [$];
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   int nf = 0;

   always #10 mclk = ~mclk;

   burst_user_logic dut (.MCLK(mclk), .RESETN(rst_n), .START(start_req),
      .DIR(dir), .LOCAL_INDEX(local_idx), .START_ADDR(start_addr),
      .TRANSFER_STOP(stop_req), .TRANSACTION_END(tend),
      .PHASE_DONE_STROBE(done), .SOURCE_ADVANCE_STROBE(adv),
      .INTERNAL_ADDR_DATA_BUS_IN(bus_in),
      .INTERNAL_ADDR_DATA_BUS_OUT(bus_out),
      .INTERNAL_ADDR_DATA_BUS_OE(oe), .ADDR_OUT(addr),
      .FILL_VALID(fill_valid), .FILL_DATA(fill_data),
      .FILL_READY(fill_ready), .DRAIN_VALID(drain_valid),
      .DRAIN_DATA(drain_data), .DRAIN_READY(drain_ready),
      .TOTALLY_EMPTY_FLAG(t_empty), .TOTALLY_FULL_FLAG(t_full),
      .ALMOST_EMPTY_FLAG(a_empty), .ALMOST_FULL_FLAG(a_full),
      .FINISH_REQUEST(finish_req), .REQUEST_ERROR(req_err),
      .OVERRUN_ERROR(ovr_err), .BUSY(busy));

   core_model m (.clk(mclk), .bus_out(bus_out), .done(done), .adv(adv),
      .tend(tend), .bus_in(bus_in), .taken_word(taken_word),
      .taken_valid(taken_valid));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) m.step(1'b0, 1'b0, 1'b0, 32'h0000_0000);
   endtask

   task automatic begin_xfer(input logic d, input logic l,
      input logic [31:0] a);
      @(negedge mclk);
      start_req = 1'b1;
      dir = d;
      local_idx = l;
      start_addr = a;
      @(negedge mclk);
      start_req = 1'b0;
   endtask

   task automatic end_xfer();
      @(negedge mclk);
      stop_req = 1'b1;
      @(negedge mclk);
      stop_req = 1'b0;
   endtask

   // Offer 20 random words, recording those the FIFO takes
   task automatic fill();
      for (int i = 0; i < 20; i++) begin
         @(negedge mclk);
         fill_valid = 1'b1;
         fill_data = $urandom;
         // Ready is registered, so its value now stands at the next edge
         if (fill_ready === 1'b1) begin
            fw[nf] = fill_data;
            nf++;
         end
      end
      @(negedge mclk);
      fill_valid = 1'b0;
   endtask

   // Empty the FIFO with a randomly stalling consumer
   task automatic drain();
      for (int i = 0; i < 300 && drain_q.size() > 0; i++) begin
         @(negedge mclk);
         drain_ready = 1'($urandom);
      end
      @(negedge mclk);
      drain_ready = 1'b0;
      chk("drain_left", 32'h0000_0000, 32'(drain_q.size()));
   endtask

   // Results taken off the queues in order as they appear
   always @(posedge mclk) begin
      if (rst_n && drain_valid === 1'b1 && drain_ready) begin
         if (drain_q.size() == 0) begin
            mismatches++;
            $display("mismatch drain expected none seen %h", drain_data);
         end else begin
            chk("drain", drain_q.pop_front(), drain_data);
         end
      end
      if (taken_valid === 1'b1) begin
         if (core_q.size() == 0) begin
            mismatches++;
            $display("mismatch core_word expected none seen %h", taken_word);
         end else begin
            chk("core_word", core_q.pop_front(), taken_word);
         end
      end
   end

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(35724));
      repeat (2) @(posedge mclk);
      chk1("reset_empty", 1'b1, t_empty);
      chk1("reset_a_empty", 1'b1, a_empty);
      chk("reset_addr", 32'h0000_0000, addr);
      @(negedge mclk);
      rst_n = 1'b1;
      begin_xfer(1'b1, 1'b0, 32'h0000_0010);
      chk1("empty_refused", 1'b1, req_err);
      chk1("empty_busy", 1'b0, busy);
      fill();
      chk("fill_count", 32'd14, 32'(nf));
      chk1("full_flag", 1'b1, t_full);
      base = $urandom;
      begin_xfer(1'b1, 1'b1, base);
      base[1:0] = 2'h0;
      chk("write_addr", base, addr);
      chk1("write_oe", 1'b1, oe);
      for (int i = 0; i < 4; i++) begin
         core_q.push_back(fw[i]);
         m.step(1'b1, 1'b0, 1'b0, 32'h0000_0000);
      end
      m.step(1'b0, 1'b1, 1'b0, 32'h0000_0000);
      chk("advance_addr", base + 32'h0000_0010, addr);
      m.step(1'b0, 1'b0, 1'b1, 32'h0000_0000);
      idle(3);
      chk("backup_addr", base + 32'h0000_0004, addr);
      core_q.push_back(fw[2]);
      m.step(1'b1, 1'b1, 1'b0, 32'h0000_0000);
      m.step(1'b0, 1'b0, 1'b1, 32'h0000_0000);
      idle(2);
      chk("second_addr", base + 32'h0000_0008, addr);
      end_xfer();
      chk1("stop_busy", 1'b0, busy);
      chk("stop_addr", base + 32'h0000_0008, addr);
      for (int i = 3; i < 14; i++) drain_q.push_back(fw[i]);
      drain();
      begin_xfer(1'b0, 1'b0, 32'hFFFF_FFFB);
      chk("read_addr", 32'hFFFF_FFF8, addr);
      for (int i = 0; i < 15; i++) begin
         w = $urandom;
         if (i < 14) drain_q.push_back(w);
         if (i == 14) idle(3);
         m.step(1'b0, 1'b1, 1'b0, w);
      end
      idle(1);
      chk1("overrun", 1'b1, ovr_err);
      chk1("finish_req", 1'b1, finish_req);
      chk1("almost_full", 1'b1, a_full);
      m.step(1'b0, 1'b0, 1'b1, 32'h0000_0000);
      idle(1);
      chk("wrap_addr", 32'h0000_0034, addr);
      end_xfer();
      begin_xfer(1'b0, 1'b0, 32'h0000_0000);
      chk1("full_refused", 1'b1, req_err);
      drain();
      chk1("end_empty", 1'b1, t_empty);
      stop_test();
   end
endmodule
